// *** rtl/hsq_pkg.sv ***
// Purpose: constants, types and plan table of the homing sequencer
// Assumes: 25 MHz clock, methods 1 to 12 only
// Notes:   the plan table is shared by start and limit reversal
// Function
// (R1) m1 neg limit active: positive low, index
// (R2) m2 positive fast, reverse slow, index
// (R3) m2 pos limit active: positive low, index
// (R4) m3 positive fast or slow, index
// (R5) m4 switch level picks slow or fast
// (R6) m5 negative fast or positive low, index
// (R7) m6 positive low or fast, index
// (R8) m7 positive fast, reverse slow, index
// (R9) m7 after limit: slow on rise
// (R10) m7 switch active: negative low, index
// (R11) m8 fast, negative low, positive low
// (R12) m8 after limit: same slow pattern
// (R13) m8 switch active: negative then positive
// (R14) m9 positive fast then positive low
// (R15) m9 after limit: positive then negative
// (R16) m9 switch active: positive then negative
// (R17) m10 positive fast then positive low
// (R18) m10 after limit: positive low, index
// (R19) m11 negative fast, negative low, index
// (R20) m11 negative limit reverses fast search
// (R21) m12 negative fast, positive, negative low
// (R22) positive limit reverses initial fast search
// (R23) host raises start, holds, clears to end
// (R24) attained flag reports success at completion
// (R25) error flag on timeout or deviation
// (R26) timeout raises homing timeout alarm
// (R27) method and levels sampled at start
// (R28) inputs synchronised, debounced, edge detected
package hsq_pkg;

  // -------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_TIME_NS    = 1_000_000;
  localparam int MS_CYCLES     = MS_TIME_NS / CLK_PERIOD_NS;
  localparam int SW_DEB_NS     = 1_000;
  localparam int SW_DEB_CYC    = (SW_DEB_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int IDX_DEB_NS    = 80;
  localparam int IDX_DEB_CYC   = (IDX_DEB_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int METHOD_FIRST  = 1;
  localparam int METHOD_LAST   = 12;
  localparam int LIMIT_AWARE   = 7;

  // -------------------------------------------------------------------
  // types
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    SIG_NLIM = 2'h0,
    SIG_PLIM = 2'h1,
    SIG_HOME = 2'h2
  } hsq_sig_t;

  typedef struct packed {
    logic dir_pos;   // 1 = positive travel
    logic fast;      // 1 = high search speed
    logic on_rise;   // step ends on rising edge, else falling
  } hsq_step_t;

  typedef struct packed {
    hsq_sig_t        sig;
    logic [1:0]      nsteps;
    logic            lim_aware;
    hsq_step_t [2:0] step;
  } hsq_plan_t;

  typedef struct packed {
    logic active;
    logic dir_pos;
    logic fast;
  } hsq_motion_t;

  typedef struct packed {
    logic attained;       // status bit 12
    logic error;          // status bit 13
    logic reached;        // target reached
    logic timeout_alarm;
  } hsq_status_t;

  localparam hsq_step_t PH = '{1'b1, 1'b1, 1'b1};
  localparam hsq_step_t NH = '{1'b0, 1'b1, 1'b1};
  localparam hsq_step_t PL = '{1'b1, 1'b0, 1'b1};
  localparam hsq_step_t NL = '{1'b0, 1'b0, 1'b1};

  function automatic hsq_step_t sf(hsq_step_t s, logic rise);
    sf         = s;
    sf.on_rise = rise;
  endfunction

  function automatic hsq_plan_t mk(hsq_sig_t g, logic [1:0] n,
                                   hsq_step_t a, hsq_step_t b,
                                   hsq_step_t c);
    mk = '{g, n, 1'b0, {c, b, a}};
  endfunction

  // act: switch level at start; lim: fast search already hit a limit
  function automatic hsq_plan_t hsq_plan(logic [3:0] m, logic act,
                                         logic lim);
    hsq_plan_t p;
    p = mk(SIG_HOME, 2'h0, PL, PL, PL);
    case (m)
      4'h1: p = act ? mk(SIG_NLIM, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_NLIM, 2'h2, NH, sf(PL,1'b0), PL);
      4'h2: p = act ? mk(SIG_PLIM, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_PLIM, 2'h2, PH, sf(NL,1'b0), PL);
      4'h3: p = act ? mk(SIG_HOME, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h2, PH, sf(NL,1'b0), PL);
      4'h4: p = act ? mk(SIG_HOME, 2'h2, sf(NH,1'b0), NL, PL)
                    : mk(SIG_HOME, 2'h1, PL, PL, PL);
      4'h5: p = act ? mk(SIG_HOME, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h2, NH, sf(PL,1'b0), PL);
      4'h6: p = act ? mk(SIG_HOME, 2'h2, sf(PH,1'b0), NL, PL)
                    : mk(SIG_HOME, 2'h1, PL, PL, PL);
      4'h7: p = act ? mk(SIG_HOME, 2'h1, sf(NL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h2, PH, sf(NL,1'b0), PL);
      4'h8: p = act ? mk(SIG_HOME, 2'h2, sf(NL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h3, PH, sf(NL,1'b0), PL);
      4'h9: p = act ? mk(SIG_HOME, 2'h2, sf(PL,1'b0), NL, PL)
                    : mk(SIG_HOME, 2'h3, PH, sf(PL,1'b0),
                         lim ? NL : PL);
      4'hA: p = act ? mk(SIG_HOME, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h2, PH, sf(PL,1'b0), PL);
      4'hB: p = act ? mk(SIG_HOME, 2'h1, sf(PL,1'b0), PL, PL)
                    : mk(SIG_HOME, 2'h2, NH, sf(NL,1'b0), PL);
      4'hC: p = act ? mk(SIG_HOME, 2'h2, sf(PL,1'b0), NL, PL)
                    : mk(SIG_HOME, 2'h3, NH, sf(PL,1'b0), NL);
      default: p = mk(SIG_HOME, 2'h0, PL, PL, PL);
    endcase
    p.lim_aware = (m >= 4'(LIMIT_AWARE)) && !act;
    if (lim)
      p.step[0].dir_pos = !p.step[0].dir_pos;
    return p;
  endfunction

endpackage

// *** rtl/hsq_input_cond.sv ***
// Purpose: synchronise, debounce and edge-detect one switch input
// Assumes: DEB_CYC below 256
// Notes:   edges are one-cycle pulses in the same cycle as the level moves
module hsq_input_cond
  import hsq_pkg::*;
#(
  parameter int DEB_CYC = 2
) (
  input  wire logic clk,    // system clock
  input  wire logic reset,  // synchronous reset, high
  input  wire logic raw,    // raw pin level
  output logic      level,  // debounced level
  output logic      rise,   // rising edge pulse
  output logic      fall    // falling edge pulse
);
  logic       s1_q;
  logic       s2_q;
  logic [7:0] cnt_q;

  always_ff @(posedge clk) begin
    s1_q <= reset ? 1'b0 : raw;
    s2_q <= reset ? 1'b0 : s1_q;
  end

  // a change must persist for DEB_CYC cycles before it is accepted
  always_ff @(posedge clk) begin
    rise <= 1'b0;
    fall <= 1'b0;
    if (reset) begin
      level <= 1'b0;
      cnt_q <= 8'h00;
    end else if (s2_q == level) begin
      cnt_q <= 8'h00;
    end else if (cnt_q >= 8'(DEB_CYC - 1)) begin
      level <= s2_q;
      cnt_q <= 8'h00;
      rise  <= s2_q;     // R28
      fall  <= !s2_q;    // R28
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  chk_edge_single: assert property (@(posedge clk) disable iff (reset)
    (rise || fall) |=> !(rise || fall) && $stable(level)) // R28
    else $error("edge pulse lasted more than one cycle");

endmodule // hsq_input_cond

// *** rtl/hsq_timer.sv ***
// Purpose: homing duration watchdog in milliseconds
// Assumes: a limit of zero disables the watchdog
// Notes:   millisecond tick comes from a cycle divider
module hsq_timer
  import hsq_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        clk,       // system clock
  input  wire logic        reset,     // synchronous reset, high
  input  wire logic        run,       // homing in progress
  input  wire logic [15:0] limit_ms,  // duration limit, ms
  output logic             expired    // limit reached, level
);
  logic [24:0] div_q;
  logic [15:0] ms_q;
  logic        tick;

  assign tick = (div_q == 25'(MS_CYC - 1));

  always_ff @(posedge clk) begin
    if (reset || !run || tick)
      div_q <= 25'h0000000;
    else
      div_q <= div_q + 25'h0000001;
  end

  always_ff @(posedge clk) begin
    if (reset || !run)
      ms_q <= 16'h0000;
    else if (tick && ms_q != 16'hFFFF)
      ms_q <= ms_q + 16'h0001;
  end

  always_ff @(posedge clk) begin
    if (reset || !run)
      expired <= 1'b0;
    else if (limit_ms != 16'h0000 && ms_q >= limit_ms)
      expired <= 1'b1;    // R26
  end

endmodule // hsq_timer

// *** rtl/hsq_top.sv ***
// Purpose: homing sequencer for methods 1 to 12
// Assumes: host holds start high for the whole sequence
// Notes:   motion outputs follow the state one cycle later
module hsq_top
  import hsq_pkg::*;
#(
  parameter int MS_CYC = MS_CYCLES
) (
  input  wire logic        clk,                   // 25 MHz clock
  input  wire logic        reset,                 // sync reset, high
  input  wire logic        homing_start,          // control bit 4
  input  wire logic [15:0] homing_method_select,  // method number
  input  wire logic        negative_limit_input,  // negative limit
  input  wire logic        positive_limit_input,  // positive limit
  input  wire logic        home_switch_input,     // home switch
  input  wire logic        index_pulse_input,     // motor index
  input  wire logic        deviation_excess,      // deviation fault
  input  wire logic [15:0] homing_time_limit_ms,  // duration limit
  output hsq_motion_t      motion,                // speed command
  output hsq_status_t      status,                // status flags
  output logic             homing_timeout_alarm   // timeout alarm
);

  // -------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00001,
    ST_SEARCH = 5'b00010,
    ST_INDEX  = 5'b00100,
    ST_DONE   = 5'b01000,
    ST_FAIL   = 5'b10000
  } hsq_state_t;

  hsq_state_t  state_q;
  hsq_plan_t   plan_q;
  logic [1:0]  step_q;
  logic [3:0]  method_q;
  logic        init_act_q;
  logic        lim_done_q;
  logic        start_q;
  logic        err_q;
  logic        tmo_q;

  logic [2:0]  lvl;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic        idx_lvl;
  logic        idx_rise;
  logic        idx_fall;
  logic        expired;

  // -------------------------------------------------------------------
  // input conditioning
  // -------------------------------------------------------------------
  hsq_input_cond #(.DEB_CYC(SW_DEB_CYC)) u_nlim (
    .clk   (clk),
    .reset (reset),
    .raw   (negative_limit_input),
    .level (lvl[SIG_NLIM]),
    .rise  (rise[SIG_NLIM]),
    .fall  (fall[SIG_NLIM])
  );

  hsq_input_cond #(.DEB_CYC(SW_DEB_CYC)) u_plim (
    .clk   (clk),
    .reset (reset),
    .raw   (positive_limit_input),
    .level (lvl[SIG_PLIM]),
    .rise  (rise[SIG_PLIM]),
    .fall  (fall[SIG_PLIM])
  );

  hsq_input_cond #(.DEB_CYC(SW_DEB_CYC)) u_home (
    .clk   (clk),
    .reset (reset),
    .raw   (home_switch_input),
    .level (lvl[SIG_HOME]),
    .rise  (rise[SIG_HOME]),
    .fall  (fall[SIG_HOME])
  );

  // index pulses are short, so the filter is only a few cycles
  hsq_input_cond #(.DEB_CYC(IDX_DEB_CYC)) u_index (
    .clk   (clk),
    .reset (reset),
    .raw   (index_pulse_input),
    .level (idx_lvl),
    .rise  (idx_rise),
    .fall  (idx_fall)
  );

  hsq_timer #(.MS_CYC(MS_CYC)) u_timer (
    .clk      (clk),
    .reset    (reset),
    .run      (state_q == ST_SEARCH || state_q == ST_INDEX),
    .limit_ms (homing_time_limit_ms),
    .expired  (expired)
  );

  // -------------------------------------------------------------------
  // decode
  // -------------------------------------------------------------------
  logic       start_rise;
  logic       method_ok;
  logic [3:0] method_in;
  logic       act_in;
  hsq_step_t  cur;
  logic       step_edge;
  logic       last_step;
  logic       lim_hit;
  logic       fault;
  logic       running;

  assign start_rise = homing_start && !start_q;
  assign method_ok  = $signed(homing_method_select) >= METHOD_FIRST
                   && $signed(homing_method_select) <= METHOD_LAST;
  assign method_in  = homing_method_select[3:0];
  assign act_in     = (method_in == 4'h1) ? lvl[SIG_NLIM]
                    : (method_in == 4'h2) ? lvl[SIG_PLIM]
                    : lvl[SIG_HOME];
  assign cur        = plan_q.step[step_q];
  assign step_edge  = cur.on_rise ? rise[plan_q.sig] : fall[plan_q.sig];
  assign last_step  = (step_q == plan_q.nsteps - 2'h1);
  // a limit in the direction of the first fast search turns it round
  assign lim_hit    = (state_q == ST_SEARCH) && step_q == 2'h0
                   && plan_q.lim_aware && !lim_done_q
                   && (cur.dir_pos ? rise[SIG_PLIM] : rise[SIG_NLIM]);
  assign fault      = expired || deviation_excess;
  assign running    = (state_q == ST_SEARCH || state_q == ST_INDEX);

  always_ff @(posedge clk) begin
    start_q <= reset ? 1'b0 : homing_start;
  end

  // -------------------------------------------------------------------
  // sequence state
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start_rise)
            state_q <= method_ok ? ST_SEARCH : ST_FAIL;
        end
        ST_SEARCH: begin
          if (!homing_start)
            state_q <= ST_IDLE;
          else if (fault)
            state_q <= ST_FAIL;                        // R25
          else if (step_edge && last_step && !lim_hit)
            state_q <= ST_INDEX;
        end
        ST_INDEX: begin
          if (!homing_start)
            state_q <= ST_IDLE;
          else if (fault)
            state_q <= ST_FAIL;                        // R25
          else if (idx_rise)
            state_q <= ST_DONE;                        // R1 R2 R3
        end
        ST_DONE, ST_FAIL: begin
          if (!homing_start)
            state_q <= ST_IDLE;
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // plan and step tracking
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      method_q   <= 4'h0;
      init_act_q <= 1'b0;
      plan_q     <= hsq_plan(4'h0, 1'b0, 1'b0);
    end else if (state_q == ST_IDLE && start_rise) begin
      method_q   <= method_in;                         // R27
      init_act_q <= act_in;                            // R27
      plan_q     <= hsq_plan(method_in, act_in, 1'b0); // R4 R5 R6 R7 R19
    end else if (lim_hit) begin
      plan_q <= hsq_plan(method_q, init_act_q, 1'b1);  // R22 R20 R9
    end
  end

  always_ff @(posedge clk) begin
    if (reset || state_q == ST_IDLE) begin
      step_q     <= 2'h0;
      lim_done_q <= 1'b0;
    end else if (lim_hit) begin
      lim_done_q <= 1'b1;                              // R12 R15 R18
    end else if (state_q == ST_SEARCH && step_edge && !last_step) begin
      step_q <= step_q + 2'h1;                         // R11 R14 R21
    end
  end

  // -------------------------------------------------------------------
  // fault flags
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || start_rise) begin
      err_q <= 1'b0;
      tmo_q <= 1'b0;
    end else if ((state_q == ST_SEARCH || state_q == ST_INDEX)
                 && homing_start && fault) begin
      err_q <= 1'b1;                                   // R25
      tmo_q <= expired;                                // R26
    end
  end

  // -------------------------------------------------------------------
  // outputs
  // -------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      motion <= '0;
    end else begin
      motion.active  <= running;
      // direction reads low while stopped so idle outputs are all zero
      motion.dir_pos <= running && cur.dir_pos;        // R8 R10 R13
      // the index search always runs at the slow speed
      motion.fast    <= (state_q == ST_SEARCH) && cur.fast; // R16 R17
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      status               <= '0;
      homing_timeout_alarm <= 1'b0;
    end else begin
      status.attained      <= (state_q == ST_DONE);    // R24
      status.reached       <= (state_q == ST_DONE || state_q == ST_FAIL);
      status.error         <= err_q;                   // R25
      status.timeout_alarm <= tmo_q;                   // R26
      homing_timeout_alarm <= tmo_q;                   // R26
    end
  end

  // -------------------------------------------------------------------
  // checks
  // -------------------------------------------------------------------
  chk_start_search: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_IDLE && start_rise && method_ok
    |=> state_q == ST_SEARCH ##1 motion.active) // R27
    else $error("valid start did not begin the search");

  chk_method_held: assert property (@(posedge clk) disable iff (reset)
    state_q != ST_IDLE && !start_rise |=> $stable(method_q)) // R27
    else $error("method changed during homing");

  chk_limit_turn: assert property (@(posedge clk) disable iff (reset)
    lim_hit && !fault && homing_start
    |=> ##1 motion.fast && motion.dir_pos != $past(motion.dir_pos)) // R22
    else $error("limit did not reverse the fast search");

  chk_last_edge: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_SEARCH && homing_start && !fault && step_edge
    && last_step && !lim_hit
    |=> state_q == ST_INDEX ##1 !motion.fast) // R8
    else $error("final edge did not enter index wait");

  chk_index_stop: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_INDEX && homing_start && !fault && idx_rise
    |=> ##1 !motion.active && status.attained && !status.error) // R1
    else $error("index pulse did not stop homing");

  chk_fault_error: assert property (@(posedge clk) disable iff (reset)
    state_q == ST_SEARCH && homing_start && deviation_excess
    |=> ##1 status.error && !status.attained) // R25
    else $error("deviation did not flag homing error");

  chk_timeout_flag: assert property (@(posedge clk) disable iff (reset)
    running && homing_start && expired
    |=> ##1 homing_timeout_alarm && status.timeout_alarm) // R26
    else $error("timeout did not raise the alarm");

  chk_clear_idle: assert property (@(posedge clk) disable iff (reset)
    state_q != ST_IDLE && !homing_start
    |=> state_q == ST_IDLE ##1 !motion.active) // R23
    else $error("clearing start did not end homing");

  chk_attain_valid: assert property (@(posedge clk) disable iff (reset)
    status.attained |-> status.reached && !status.error) // R24
    else $error("attained shown without target reached");

endmodule // hsq_top

// *** sim/hsq_axis_model.sv ***
// Purpose: axis model with limits, home switch and index pulse
// Assumes: motion comes from the sequencer under test
// Notes:   pins move at the falling edge, never released or unknown
module hsq_axis_model
  import hsq_pkg::*;
(
  input  wire logic   clk,     // system clock
  input  hsq_motion_t motion,  // speed command
  input  wire logic   load,    // load start position
  input  int          pos0,    // start position
  input  int          h_lo,    // home switch window low end
  input  int          h_hi,    // home switch window high end
  input  int          nl,      // negative limit below this
  input  int          pl,      // positive limit above this
  output logic        nlim,    // negative limit pin
  output logic        plim,    // positive limit pin
  output logic        home,    // home switch pin
  output logic        index    // index pulse pin
);
  timeunit 1ns;
  timeprecision 1ns;
  int pos = 0;
  int spd;
  // fast is only 4x slow so a fast pass still outlasts the debounce
  assign spd = motion.fast ? 4 : 1;
  always @(negedge clk) begin
    if (load)
      pos <= pos0;
    else if (motion.active)
      pos <= motion.dir_pos ? pos + spd : pos - spd;
  end
  assign nlim  = pos < nl;
  assign plim  = pos > pl;
  assign home  = pos >= h_lo && pos <= h_hi;
  assign index = pos[5:0] < 6'h04;
endmodule // hsq_axis_model

// *** sim/test_hsq_top.sv ***
// Purpose: self-checking bench of the homing sequencer
// Assumes: millisecond divider shortened to 10 cycles
// Notes:   motion changes are logged as {dir_pos, fast} codes
`define CHK(a, b) begin \
  num_checks++; \
  if ((a) !== (b)) begin \
    error_cnt++; \
    $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, a, b); \
  end \
end
module test_hsq_top
  import hsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        reset            = 1'b1;
  logic        homing_start     = 1'b0;
  logic [15:0] method           = 16'h0000;
  logic        deviation_excess = 1'b0;
  logic [15:0] limit_ms         = 16'h0000;
  logic        load             = 1'b0;
  int          pos0             = 0;
  int          h_lo             = 5000;
  int          h_hi             = 5100;
  int          nl               = -3000;
  int          pl               = 3000;
  logic        nlim, plim, home, index;
  hsq_motion_t motion, last_m;
  hsq_status_t status;
  logic        alarm;
  logic [1:0]  log_q[$];
  int          error_cnt        = 0;
  int          num_checks       = 0;
  int          cyc              = 0;

  hsq_top #(.MS_CYC(10)) hsq_top_i (
    .clk(clk), .reset(reset), .homing_start(homing_start),
    .homing_method_select(method), .negative_limit_input(nlim),
    .positive_limit_input(plim), .home_switch_input(home),
    .index_pulse_input(index), .deviation_excess(deviation_excess),
    .homing_time_limit_ms(limit_ms), .motion(motion),
    .status(status), .homing_timeout_alarm(alarm));
  hsq_axis_model hsq_axis_model_i (
    .clk(clk), .motion(motion), .load(load), .pos0(pos0), .h_lo(h_lo),
    .h_hi(h_hi), .nl(nl), .pl(pl), .nlim(nlim), .plim(plim),
    .home(home), .index(index));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    if (motion.active === 1'b1 && motion !== last_m)
      log_q.push_back({motion.dir_pos, motion.fast});
    last_m <= motion;
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      complete_run();
    end
  end

  // -------------------------------------------------------------------
  // shared steps
  // -------------------------------------------------------------------
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic prep(input int m, p0, lo, hi, n, p);
    pos0 = p0;
    h_lo = lo;
    h_hi = hi;
    nl = n;
    pl = p;
    load = 1'b1;
    repeat (2) @(negedge clk);
    load = 1'b0;
    method = 16'(m);
    limit_ms = 16'h2000;
    // let the debounced levels settle before the start edge samples them
    repeat (40) @(negedge clk);
    log_q.delete();
  endtask

  // error flags survive the stop and clear only on the next start edge
  task automatic stop(input logic [3:0] ex);
    homing_start = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(status, ex)
    `CHK(motion, 3'h0)
  endtask

  task automatic wait_done(input int lim, output int k);
    for (k = 0; k < lim && status.reached !== 1'b1; k++)
      @(negedge clk);
  endtask

  // codes: 3 positive fast, 1 negative fast, 2 positive slow, 0 neg slow
  task automatic go(input int m, p0, lo, hi, n, p,
                    input logic [7:0] ex, input int cnt);
    int k;
    logic [7:0] acc;
    acc = 8'h00;
    prep(m, p0, lo, hi, n, p);
    homing_start = 1'b1;
    wait_done(9000, k);
    foreach (log_q[i]) acc = {acc[5:0], log_q[i]};
    `CHK(log_q.size(), cnt)
    `CHK(acc, ex)
    `CHK(status, 4'hA)
    `CHK(alarm, 1'b0)
    stop(4'h0);
  endtask

  // -------------------------------------------------------------------
  // scenarios
  // -------------------------------------------------------------------
  task automatic t_free_run();
    prep(9, 0, 400, 700, -3000, 3000);
    homing_start = 1'b1;
    repeat (500) @(negedge clk);
    // past the window the search keeps going positive at low speed
    `CHK(motion, 3'h6)
    `CHK(status.reached, 1'b0)
    `CHK(log_q.size(), 2)
    stop(4'h0);
  endtask

  task automatic t_limit_ref();
    go(1, -400, 5000, 5100, -300, 3000, 8'h02, 1);
    go(2, 0, 5000, 5100, -3000, 300, 8'h0C, 2);
  endtask

  task automatic t_home_basic();
    go(3, 0, 400, 700, -3000, 3000, 8'h0C, 2);
    go(3, 500, 400, 700, -3000, 3000, 8'h02, 1);
    go(4, 0, 400, 700, -3000, 3000, 8'h02, 1);
    go(5, 0, -700, -400, -3000, 3000, 8'h06, 2);
    go(6, 0, 400, 700, -3000, 3000, 8'h02, 1);
    go(6, 500, 400, 700, -3000, 3000, 8'h0C, 2);
  endtask

  task automatic t_limit_aware();
    go(7, 0, 400, 700, -3000, 3000, 8'h0C, 2);
    go(7, 0, -700, -400, -3000, 300, 8'h34, 3);
    go(7, 500, 400, 700, -3000, 3000, 8'h00, 1);
    go(8, 0, 400, 700, -3000, 3000, 8'h32, 3);
    go(8, 0, -700, -400, -3000, 300, 8'hD2, 4);
    go(8, 500, 400, 700, -3000, 3000, 8'h02, 2);
    go(9, 0, -700, -400, -3000, 300, 8'hD8, 4);
    go(9, 500, 400, 700, -3000, 3000, 8'h08, 2);
    go(10, 0, 400, 700, -3000, 3000, 8'h0E, 2);
    go(10, 0, -700, -400, -3000, 300, 8'h36, 3);
  endtask

  task automatic t_negative();
    go(11, 0, -700, -400, -3000, 3000, 8'h04, 2);
    go(11, 500, 400, 700, -3000, 3000, 8'h02, 1);
    go(11, 0, 400, 700, -300, 3000, 8'h1C, 3);
    go(12, 0, -700, -400, -3000, 3000, 8'h18, 3);
  endtask

  task automatic t_timeout();
    int k;
    prep(3, 0, 9000, 9100, -9999, 9999);
    limit_ms = 16'h0005;
    homing_start = 1'b1;
    wait_done(400, k);
    `CHK(k >= 40, 1'b1)
    `CHK(status, 4'h7)
    `CHK(alarm, 1'b1)
    `CHK(motion.active, 1'b0)
    stop(4'h5);
  endtask

  task automatic t_deviation();
    int k;
    prep(3, 0, 9000, 9100, -9999, 9999);
    limit_ms = 16'h0000;
    homing_start = 1'b1;
    repeat (100) @(negedge clk);
    // a zero limit must leave the watchdog quiet
    `CHK(status.reached, 1'b0)
    deviation_excess = 1'b1;
    wait_done(20, k);
    deviation_excess = 1'b0;
    `CHK(status, 4'h6)
    `CHK(alarm, 1'b0)
    stop(4'h4);
  endtask

  task automatic t_unsupported();
    int k;
    prep(13, 0, 400, 700, -3000, 3000);
    homing_start = 1'b1;
    wait_done(20, k);
    `CHK(status, 4'h2)
    `CHK(log_q.size(), 0)
    stop(4'h0);
  endtask

  initial begin
    repeat (20) @(negedge clk);
    reset = 1'b0;
    t_limit_ref();
    t_home_basic();
    t_limit_aware();
    t_free_run();
    t_negative();
    t_timeout();
    t_deviation();
    t_unsupported();
    complete_run();
  end
endmodule // test_hsq_top
